/* hw/css_params.svh */
// register offsets, field positions and reset values of the core registers
// assumes the includer maps each index to byte address index*4 on apb
`ifndef CSS_PARAMS_SVH
`define CSS_PARAMS_SVH

// register indices; byte address is four times the index
`define CSS_IDX_STACK_POINTER 8'h81
`define CSS_IDX_DATA_POINTER_LOW 8'h82
`define CSS_IDX_DATA_POINTER_HIGH 8'h83
`define CSS_IDX_STATUS_WORD 8'hD0
`define CSS_IDX_WORK 8'hE0
`define CSS_IDX_AUX 8'hF0

// apb byte address width, word index sits in paddr[9:2]
`define CSS_ADDR_W 10

// reset values
`define CSS_RST_STACK_POINTER 8'h07
`define CSS_RST_DATA_POINTER 8'h00
`define CSS_RST_STATUS_WORD 8'h00
`define CSS_RST_WORK 8'h00
`define CSS_RST_AUX 8'h00

// status word field positions
`define CSS_BIT_CARRY_FLAG 7
`define CSS_BIT_HALF_CARRY_FLAG 6
`define CSS_BIT_USER_FLAG_ZERO 5
`define CSS_BIT_BANK_SELECT_HIGH 4
`define CSS_BIT_BANK_SELECT_LOW 3
`define CSS_BIT_SIGNED_RANGE_FLAG 2
`define CSS_BIT_USER_FLAG_ONE 1
`define CSS_BIT_PARITY 0

`endif

/* hw/css_pkg.sv */
// types shared by the core register block and its testbench
// assumes nothing beyond a sv-2012 compiler
package css_pkg;
    // operations the cpu datapath hands to the register block
    typedef enum logic [3:0] {
        CSS_OP_LOAD,
        CSS_OP_ADD,
        CSS_OP_ADDC,
        CSS_OP_SUBB,
        CSS_OP_MUL,
        CSS_OP_DIV,
        CSS_OP_SETC,
        CSS_OP_CLRC,
        CSS_OP_CPLC,
        CSS_OP_ANDC,
        CSS_OP_ORC,
        CSS_OP_MOVC
    } css_op_t;
endpackage : css_pkg

/* hw/css_ram_if.sv */
// port bundle between the register block and its stack memory
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface css_ram_if;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface : css_ram_if

/* hw/css_stack_ram.sv */
// 256-byte on-chip stack memory with registered read data
// assumes a single clock; write and read share one address per cycle
`timescale 1ns/1ps
module css_stack_ram (
    input wire logic pclk, // core clock
    input wire logic presetn, // async reset, active low
    css_ram_if.mem ram // access port
);
    logic [7:0] mem_q [256];
    logic [7:0] rdata_ff;

    // array has no reset: contents are undefined after power-up
    always_ff @(posedge pclk) begin
        if (ram.we) begin
            mem_q[ram.addr] <= ram.wdata;
        end
    end

    // read data always from a flop, one cycle after the address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= mem_q[ram.addr];
        end
    end

    assign ram.rdata = rdata_ff;
endmodule : css_stack_ram

/* hw/css_core_regs.sv */
// cpu core registers: stack pointer, status word, work, aux, data pointer
// assumes an apb master on pclk and a datapath issuing ops on pclk
`timescale 1ns/1ps
`include "css_params.svh"
module css_core_regs (
    input wire logic pclk, // core clock, 100 mhz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, 1 = write
    input wire logic [`CSS_ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped word
    input wire logic exe_valid, // datapath op strobe
    input wire css_pkg::css_op_t exe_op, // datapath op code
    input wire logic [7:0] exe_operand, // second operand byte
    input wire logic exe_bit, // bit operand for boolean ops
    input wire logic push_valid, // push strobe
    input wire logic [7:0] push_data, // byte to push
    input wire logic pop_valid, // pop strobe
    output logic [7:0] pop_data, // popped byte
    output logic pop_done, // popped byte valid pulse
    output logic [7:0] work_value, // work register
    output logic [7:0] aux_value, // aux register
    output logic [15:0] dptr_value, // data pointer
    output logic [7:0] stack_pointer_value, // stack pointer
    output logic [7:0] status_value, // status word
    output logic [4:0] bank_base // base of active working bank
);
    import css_pkg::*;

    logic [7:0] stack_pointer_ff, nxt_stack_pointer;
    logic [7:0] dptr_lo_ff, nxt_dptr_lo;
    logic [7:0] dptr_hi_ff, nxt_dptr_hi;
    logic [7:0] status_ff, nxt_status;
    logic [7:0] work_ff, nxt_work;
    logic [7:0] aux_ff, nxt_aux;
    logic [31:0] prdata_ff;
    logic pop_done_ff;
    css_ram_if ram_bus ();

    // apb decode on the word index; low address bits are ignored
    wire [7:0] word_idx = paddr[9:2];
    wire apb_setup = psel & ~penable;
    wire apb_access = psel & penable;
    wire hit_stack_pointer = (word_idx == `CSS_IDX_STACK_POINTER);
    wire hit_dptr_lo = (word_idx == `CSS_IDX_DATA_POINTER_LOW);
    wire hit_dptr_hi = (word_idx == `CSS_IDX_DATA_POINTER_HIGH);
    wire hit_status = (word_idx == `CSS_IDX_STATUS_WORD);
    wire hit_work = (word_idx == `CSS_IDX_WORK);
    wire hit_aux = (word_idx == `CSS_IDX_AUX);
    wire mapped = hit_stack_pointer | hit_dptr_lo | hit_dptr_hi | hit_status
        | hit_work | hit_aux;
    wire wr_en = apb_access & pwrite & mapped;
    wire wr_status = wr_en & hit_status;

    // read mux, captured in setup so the access phase needs no wait
    wire [7:0] rd_byte = hit_stack_pointer ? stack_pointer_ff
        : hit_dptr_lo ? dptr_lo_ff
        : hit_dptr_hi ? dptr_hi_ff
        : hit_status ? status_ff
        : hit_work ? work_ff
        : hit_aux ? aux_ff
        : 8'h00;

    assign pready = apb_access;
    assign pslverr = apb_access & ~mapped;
    assign prdata = prdata_ff;

    // current flags
    wire carry = status_ff[`CSS_BIT_CARRY_FLAG];
    wire carry_in = (exe_op == CSS_OP_ADDC) & carry;

    // adder and subtractor with nibble carries
    wire [8:0] add_sum = {1'b0, work_ff} + {1'b0, exe_operand}
        + {8'h00, carry_in};
    wire [4:0] add_nib = {1'b0, work_ff[3:0]} + {1'b0, exe_operand[3:0]}
        + {4'h0, carry_in};
    wire [8:0] sub_diff = {1'b0, work_ff} - {1'b0, exe_operand}
        - {8'h00, carry};
    wire [4:0] sub_nib = {1'b0, work_ff[3:0]} - {1'b0, exe_operand[3:0]}
        - {4'h0, carry};
    wire range_add = (work_ff[7] == exe_operand[7])
        & (add_sum[7] != work_ff[7]);
    wire range_sub = (work_ff[7] != exe_operand[7])
        & (sub_diff[7] != work_ff[7]);

    // multiply and divide against the aux register
    wire [15:0] mul_prod = {8'h00, work_ff} * {8'h00, aux_ff};
    wire div_zero = (aux_ff == 8'h00);
    wire [7:0] div_quot = div_zero ? work_ff : work_ff / aux_ff;
    wire [7:0] div_rem = div_zero ? aux_ff : work_ff % aux_ff;

    // stack port: push wins over a same-cycle pop
    wire do_push = push_valid;
    wire do_pop = pop_valid & ~push_valid;
    wire [7:0] push_addr = stack_pointer_ff + 8'h01;

    assign ram_bus.we = do_push;
    assign ram_bus.addr = do_push ? push_addr : stack_pointer_ff;
    assign ram_bus.wdata = push_data;

    // next state for datapath ops, then software writes on top
    always_comb begin
        nxt_work = work_ff;
        nxt_aux = aux_ff;
        nxt_status = status_ff;
        nxt_dptr_lo = dptr_lo_ff;
        nxt_dptr_hi = dptr_hi_ff;
        nxt_stack_pointer = stack_pointer_ff;
        if (exe_valid) begin
            unique case (exe_op)
                CSS_OP_LOAD: begin
                    nxt_work = exe_operand;
                end
                CSS_OP_ADD, CSS_OP_ADDC: begin
                    nxt_work = add_sum[7:0];
                    nxt_status[`CSS_BIT_CARRY_FLAG] = add_sum[8];
                    nxt_status[`CSS_BIT_HALF_CARRY_FLAG] = add_nib[4];
                    nxt_status[`CSS_BIT_SIGNED_RANGE_FLAG] = range_add;
                end
                CSS_OP_SUBB: begin
                    nxt_work = sub_diff[7:0];
                    nxt_status[`CSS_BIT_CARRY_FLAG] = sub_diff[8];
                    nxt_status[`CSS_BIT_HALF_CARRY_FLAG] = sub_nib[4];
                    nxt_status[`CSS_BIT_SIGNED_RANGE_FLAG] = range_sub;
                end
                CSS_OP_MUL: begin
                    nxt_work = mul_prod[7:0];
                    nxt_aux = mul_prod[15:8];
                    nxt_status[`CSS_BIT_CARRY_FLAG] = 1'b0;
                    nxt_status[`CSS_BIT_HALF_CARRY_FLAG] = 1'b0;
                    nxt_status[`CSS_BIT_SIGNED_RANGE_FLAG] =
                        (mul_prod[15:8] != 8'h00);
                end
                CSS_OP_DIV: begin
                    nxt_work = div_quot;
                    nxt_aux = div_rem;
                    nxt_status[`CSS_BIT_CARRY_FLAG] = 1'b0;
                    nxt_status[`CSS_BIT_HALF_CARRY_FLAG] = 1'b0;
                    nxt_status[`CSS_BIT_SIGNED_RANGE_FLAG] = div_zero;
                end
                CSS_OP_SETC: begin
                    nxt_status[`CSS_BIT_CARRY_FLAG] = 1'b1;
                end
                CSS_OP_CLRC: begin
                    nxt_status[`CSS_BIT_CARRY_FLAG] = 1'b0;
                end
                CSS_OP_CPLC: begin
                    nxt_status[`CSS_BIT_CARRY_FLAG] = ~carry;
                end
                CSS_OP_ANDC: begin
                    nxt_status[`CSS_BIT_CARRY_FLAG] = carry & exe_bit;
                end
                CSS_OP_ORC: begin
                    nxt_status[`CSS_BIT_CARRY_FLAG] = carry | exe_bit;
                end
                CSS_OP_MOVC: begin
                    nxt_status[`CSS_BIT_CARRY_FLAG] = exe_bit;
                end
            endcase
        end
        // pre-increment on push, post-decrement on pop, 8-bit wrap
        if (do_push) begin
            nxt_stack_pointer = push_addr;
        end else if (do_pop) begin
            nxt_stack_pointer = stack_pointer_ff - 8'h01;
        end
        // software writes beat the datapath in the same cycle
        if (wr_en & hit_stack_pointer) begin
            nxt_stack_pointer = pwdata[7:0];
        end
        if (wr_en & hit_dptr_lo) begin
            nxt_dptr_lo = pwdata[7:0];
        end
        if (wr_en & hit_dptr_hi) begin
            nxt_dptr_hi = pwdata[7:0];
        end
        if (wr_en & hit_work) begin
            nxt_work = pwdata[7:0];
        end
        if (wr_en & hit_aux) begin
            nxt_aux = pwdata[7:0];
        end
        if (wr_status) begin
            nxt_status[7:1] = pwdata[7:1];
        end
        // parity follows whatever lands in the work register
        nxt_status[`CSS_BIT_PARITY] = ^nxt_work;
    end

    // register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_pointer_ff <= `CSS_RST_STACK_POINTER;
            dptr_lo_ff <= `CSS_RST_DATA_POINTER;
            dptr_hi_ff <= `CSS_RST_DATA_POINTER;
            status_ff <= `CSS_RST_STATUS_WORD;
            work_ff <= `CSS_RST_WORK;
            aux_ff <= `CSS_RST_AUX;
        end else begin
            stack_pointer_ff <= nxt_stack_pointer;
            dptr_lo_ff <= nxt_dptr_lo;
            dptr_hi_ff <= nxt_dptr_hi;
            status_ff <= nxt_status;
            work_ff <= nxt_work;
            aux_ff <= nxt_aux;
        end
    end

    // read data and pop strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
            pop_done_ff <= 1'b0;
        end else begin
            if (apb_setup & ~pwrite) begin
                prdata_ff <= {24'h000000, rd_byte};
            end
            pop_done_ff <= do_pop;
        end
    end

    css_stack_ram u_stack_ram (
        .pclk(pclk),
        .presetn(presetn),
        .ram(ram_bus.mem)
    );

    // outputs
    assign pop_data = ram_bus.rdata;
    assign pop_done = pop_done_ff;
    assign work_value = work_ff;
    assign aux_value = aux_ff;
    assign dptr_value = {dptr_hi_ff, dptr_lo_ff};
    assign stack_pointer_value = stack_pointer_ff;
    assign status_value = status_ff;
    assign bank_base = {status_ff[`CSS_BIT_BANK_SELECT_HIGH],
        status_ff[`CSS_BIT_BANK_SELECT_LOW], 3'b000};

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire sw_ptr_wr = wr_en & hit_stack_pointer;
    wire arith_op = exe_valid & ~wr_status & (exe_op == CSS_OP_ADD);

    a_push_preinc: assert property (
        push_valid & ~sw_ptr_wr |=> stack_pointer_ff
            == $past(stack_pointer_ff) + 8'h01
    ) else $error("stack pointer not raised by push");
    a_push_slot: assert property (
        push_valid |-> ram_bus.addr == stack_pointer_ff + 8'h01
    ) else $error("push not written above the pointer");
    a_add_carry: assert property (
        arith_op |=> carry == ({1'b0, $past(work_ff)}
            + {1'b0, $past(exe_operand)} > 9'h0FF)
    ) else $error("carry wrong after add");
    a_add_nibble: assert property (
        arith_op |=> status_ff[`CSS_BIT_HALF_CARRY_FLAG]
            == ({1'b0, $past(work_ff[3:0])}
                + {1'b0, $past(exe_operand[3:0])} > 5'h0F)
    ) else $error("half carry wrong after add");
    a_mul_wide: assert property (
        exe_valid & ~wr_status & (exe_op == CSS_OP_MUL) ##1 1
            |-> status_ff[`CSS_BIT_SIGNED_RANGE_FLAG] == (aux_ff != 8'h00)
    ) else $error("overflow wrong after multiply");
    a_div_zero: assert property (
        exe_valid & ~wr_status & (exe_op == CSS_OP_DIV) & div_zero
            |=> status_ff[`CSS_BIT_SIGNED_RANGE_FLAG]
    ) else $error("divide by zero missed overflow");
    a_parity_read: assert property (
        apb_setup & ~pwrite & hit_status ##1 apb_access
            |-> prdata[0] == ^$past(work_ff)
    ) else $error("parity does not match work register");
    a_bank_base: assert property (
        wr_status |=> bank_base == {$past(pwdata[4:3]), 3'b000}
    ) else $error("bank base does not follow status word");
    a_write_wins: assert property (
        wr_status & exe_valid |=> status_ff[7:1] == $past(pwdata[7:1])
    ) else $error("software status write lost");

    c_push_pop: cover property (push_valid ##1 pop_valid ##1 pop_done);
    c_mul_wide: cover property (exe_valid & (exe_op == CSS_OP_MUL)
        & (mul_prod[15:8] != 8'h00));
    c_status_clash: cover property (wr_status & exe_valid);
    c_ptr_wrap: cover property (push_valid & (stack_pointer_ff == 8'hFF));
endmodule : css_core_regs

/* tb/css_core_regs_tb.sv */
// self-checking bench for the core register block: apb, ops and stack
// assumes css_params.svh on the include path and css_pkg compiled first
`timescale 1ns/1ps
`include "css_params.svh"
module testbench;
    import css_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`CSS_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic exe_valid = 1'b0;
    css_op_t exe_op = CSS_OP_LOAD;
    logic [7:0] exe_operand = 8'h00;
    logic exe_bit = 1'b0;
    logic push_valid = 1'b0;
    logic [7:0] push_data = 8'h00;
    logic pop_valid = 1'b0;
    logic [7:0] pop_data;
    logic pop_done;
    logic [7:0] work_value;
    logic [7:0] aux_value;
    logic [15:0] dptr_value;
    logic [7:0] stack_pointer_value;
    logic [7:0] status_value;
    logic [4:0] bank_base;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] rd_data;
    logic rd_err;
    // register table: indices and reset values
    logic [7:0] ridx [6] = '{`CSS_IDX_STACK_POINTER, `CSS_IDX_DATA_POINTER_LOW,
        `CSS_IDX_DATA_POINTER_HIGH, `CSS_IDX_STATUS_WORD, `CSS_IDX_WORK,
        `CSS_IDX_AUX};
    logic [7:0] rrst [6] = '{`CSS_RST_STACK_POINTER, `CSS_RST_DATA_POINTER,
        `CSS_RST_DATA_POINTER, `CSS_RST_STATUS_WORD, `CSS_RST_WORK,
        `CSS_RST_AUX};
    // boolean carry ops with bit operand and expected carry afterwards
    css_op_t bops [6] = '{CSS_OP_SETC, CSS_OP_CLRC, CSS_OP_CPLC,
        CSS_OP_ANDC, CSS_OP_ORC, CSS_OP_MOVC};
    logic bbit [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic bexp [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

    css_core_regs i_css_core_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .exe_valid(exe_valid),
        .exe_op(exe_op), .exe_operand(exe_operand), .exe_bit(exe_bit),
        .push_valid(push_valid), .push_data(push_data),
        .pop_valid(pop_valid), .pop_data(pop_data), .pop_done(pop_done),
        .work_value(work_value), .aux_value(aux_value),
        .dptr_value(dptr_value), .stack_pointer_value(stack_pointer_value),
        .status_value(status_value), .bank_base(bank_base)
    );

    // 100 mhz core clock
    always #5 pclk = ~pclk;

    // hang guard; a full run needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            $display("[ERR] %0t run did not finish", $time);
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // one apb transfer; held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit: the cycle guard ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd_data, 32'(exp));
        chk_bit(rd_err, 1'b0);
    endtask : rdc

    // one datapath op; results land at the taking edge
    task automatic opc(input css_op_t o, input logic [7:0] v, input logic bv,
                       input logic [7:0] ework, input logic [7:0] estat);
        @(posedge pclk);
        exe_valid <= 1'b1;
        exe_op <= o;
        exe_operand <= v;
        exe_bit <= bv;
        @(posedge pclk);
        exe_valid <= 1'b0;
        #1;
        chk(32'(work_value), 32'(ework));
        chk(32'(status_value), 32'(estat));
    endtask : opc

    task automatic stk(input logic push, input logic [7:0] d,
                       input logic [7:0] esp);
        @(posedge pclk);
        push_valid <= push;
        pop_valid <= ~push;
        push_data <= d;
        @(posedge pclk);
        push_valid <= 1'b0;
        pop_valid <= 1'b0;
        #1;
        chk(32'(stack_pointer_value), 32'(esp));
        if (!push) begin
            chk_bit(pop_done, 1'b1);
            chk(32'(pop_data), 32'(d));
        end
    endtask : stk

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rdc(ridx[i], rrst[i]);
        $display("test reset_values finished");
        stk(1'b1, 8'h5A, 8'h08);
        stk(1'b0, 8'h5A, 8'h07);
        apb(1'b1, `CSS_IDX_STACK_POINTER, 8'hFF);
        stk(1'b1, 8'h3C, 8'h00);
        stk(1'b0, 8'h3C, 8'hFF);
        $display("test stack finished");
        apb(1'b1, `CSS_IDX_DATA_POINTER_LOW, 8'hA5);
        apb(1'b1, `CSS_IDX_DATA_POINTER_HIGH, 8'h5A);
        // the write lands at the edge apb returns on; let it settle
        #1;
        chk(32'(dptr_value), 32'h00005AA5);
        opc(CSS_OP_LOAD, 8'h7F, 1'b0, 8'h7F, 8'h01);
        opc(CSS_OP_ADD, 8'h01, 1'b0, 8'h80, 8'h45);
        opc(CSS_OP_ADD, 8'h80, 1'b0, 8'h00, 8'h84);
        opc(CSS_OP_ADDC, 8'h00, 1'b0, 8'h01, 8'h01);
        opc(CSS_OP_SUBB, 8'h02, 1'b0, 8'hFF, 8'hC0);
        opc(CSS_OP_LOAD, 8'h10, 1'b0, 8'h10, 8'hC1);
        apb(1'b1, `CSS_IDX_AUX, 8'h20);
        opc(CSS_OP_MUL, 8'h00, 1'b0, 8'h00, 8'h04);
        chk(32'(aux_value), 32'h00000002);
        opc(CSS_OP_LOAD, 8'h03, 1'b0, 8'h03, 8'h04);
        apb(1'b1, `CSS_IDX_AUX, 8'h05);
        opc(CSS_OP_MUL, 8'h00, 1'b0, 8'h0F, 8'h00);
        opc(CSS_OP_LOAD, 8'h20, 1'b0, 8'h20, 8'h01);
        opc(CSS_OP_DIV, 8'h00, 1'b0, 8'h20, 8'h05);
        apb(1'b1, `CSS_IDX_AUX, 8'h03);
        opc(CSS_OP_DIV, 8'h00, 1'b0, 8'h0A, 8'h00);
        chk(32'(aux_value), 32'h00000002);
        $display("test arithmetic finished");
        for (int i = 0; i < 6; i++)
            opc(bops[i], 8'h00, bbit[i], 8'h0A, {bexp[i], 7'h00});
        $display("test boolean finished");
        for (int bank = 0; bank < 4; bank++) begin
            apb(1'b1, `CSS_IDX_STATUS_WORD, {3'b000, 2'(bank), 3'b000});
            #1;
            chk(32'(bank_base), 32'(bank * 8));
            rdc(`CSS_IDX_STATUS_WORD, {3'b000, 2'(bank), 3'b000});
        end
        apb(1'b1, `CSS_IDX_STATUS_WORD, 8'h22);
        rdc(`CSS_IDX_STATUS_WORD, 8'h22);
        apb(1'b1, `CSS_IDX_STATUS_WORD, 8'h01);
        rdc(`CSS_IDX_STATUS_WORD, 8'h00);
        $display("test status_fields finished");
        // write lands on the same edge as an add that would set carry
        opc(CSS_OP_LOAD, 8'h80, 1'b0, 8'h80, 8'h01);
        fork
            apb(1'b1, `CSS_IDX_STATUS_WORD, 8'h22);
            begin
                repeat (2) @(posedge pclk);
                exe_valid <= 1'b1;
                exe_op <= CSS_OP_ADD;
                exe_operand <= 8'h80;
                @(posedge pclk);
                exe_valid <= 1'b0;
            end
        join
        #1;
        chk(32'(status_value), 32'h00000022);
        chk(32'(work_value), 32'h00000000);
        apb(1'b0, 8'h84, 8'h00);
        chk(rd_data, 32'h00000000);
        chk_bit(rd_err, 1'b1);
        $display("test collision_and_unmapped finished");
        tally_and_finish();
    end
endmodule : testbench
